// >>> verilog/mwob_pkg.sv
// Constants, encodings and carriers for the word-operand and bus-read datapath
package mwob_pkg;

    // Clock phases within one microcycle, one core_clk cycle each
    localparam logic [1:0] PH1 = 2'h0;
    localparam logic [1:0] PH2 = 2'h1;
    localparam logic [1:0] PH3 = 2'h2;
    localparam logic [1:0] PH4 = 2'h3;
    localparam int         PHASES_PER_MCYCLE = 4;

    // Register port offsets
    localparam logic [7:0] OFS_RF_FIRST = 8'h00;  // 16 file bytes, 0x00..0x0f
    localparam logic [7:0] OFS_RF_LAST  = 8'h0f;
    localparam logic [7:0] OFS_MI_LO    = 8'h10;
    localparam logic [7:0] OFS_MI_HI    = 8'h11;  // Write launches the microword
    localparam logic [7:0] OFS_FLAGS    = 8'h12;
    localparam logic [7:0] OFS_STATUS   = 8'h13;
    localparam logic [7:0] OFS_BUSCAP_L = 8'h14;
    localparam logic [7:0] OFS_BUSCAP_H = 8'h15;
    localparam logic [7:0] OFS_AUX      = 8'h16;

    // Flag register bit positions
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;

    // Status register bit positions
    localparam int STS_BUSY    = 0;
    localparam int STS_READING = 1;
    localparam int STS_RETRY   = 2;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Operation codes in the top nibble of the microword
    typedef enum logic [3:0] {
        OP_MOV  = 4'h0, OP_ADD  = 4'h1, OP_ADDC = 4'h2, OP_SUB  = 4'h3,
        OP_AND  = 4'h4, OP_OR   = 4'h5, OP_XOR  = 4'h6, OP_OCM  = 4'h7,
        OP_TCM  = 4'h8, OP_SHL  = 4'h9, OP_SHR  = 4'ha, OP_INC1 = 4'hb,
        OP_INC2 = 4'hc, OP_DEC1 = 4'hd, OP_READ = 4'he, OP_LAUX = 4'hf
    } mwob_op_t;

    // Read variants, carried in bits 11:9 when the op is a read
    localparam logic [2:0] RD_PLAIN = 3'h0;
    localparam logic [2:0] RD_IB1   = 3'h1;
    localparam logic [2:0] RD_IB2   = 3'h2;
    localparam logic [2:0] RD_IW1   = 3'h3;
    localparam logic [2:0] RD_IW2   = 3'h4;
    localparam logic [2:0] RD_ACK   = 3'h5;

    // Microword layout
    typedef struct packed {
        mwob_op_t   op;
        logic       word;    // Word width
        logic       flg;     // Updates condition codes
        logic       cnd;     // Runs only when carry flag is set
        logic       wcy;     // Shift chained through carry
        logic [3:0] bfld;
        logic [3:0] afld;
    } mwob_mi_t;

    // Bus control lines driven toward the system bus interface
    typedef struct packed {
        logic sync;
        logic wbyte;
        logic din;
        logic dout;
        logic iack;
    } mwob_busctl_t;

endpackage

// >>> verilog/mwob_core.sv
// Byte-wide register file, word-operand ALU and bus read sequencer
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module mwob_core (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  clk_en,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire logic [15:0]           bus_addr_data_lines_in,
    output logic      [15:0]           bus_addr_data_lines_out,
    output logic                       bus_addr_data_lines_oe_b,
    output mwob_pkg::mwob_busctl_t     bus_ctl,
    input  wire logic                  reply_in,
    input  wire logic                  busy_in,
    output logic                       exec_busy
);
    import mwob_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_EXEC, ST_RCHK, ST_RARM, ST_RADDR, ST_RPOST
    } mwob_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0]     rf_reg [16];
    logic [7:0]     aux_reg;
    logic [7:0]     mi_lo_reg;
    mwob_mi_t       mi_reg;
    mwob_state_t    state_reg;
    logic [1:0]     ph_reg;
    logic           cyc_reg;
    logic           lnk_c_reg;
    logic           lnk_z_reg;
    logic           lnk_n_reg;
    logic [3:0]     cc_reg;
    logic           retry_reg;
    logic [1:0]     reply_sync_reg;
    logic [1:0]     busy_sync_reg;
    logic [15:0]    dal_s1_reg;
    logic [15:0]    dal_s2_reg;
    logic [15:0]    buscap_reg;
    logic [1:0]     din_pipe_reg;

    logic           launch;
    logic           commit;
    logic           skip;
    logic           is_rs;
    logic           first;
    logic           last;
    logic [3:0]     a_eff;
    logic [3:0]     b_eff;
    logic [7:0]     a_byte;
    logic [7:0]     b_byte;
    logic [7:0]     x_op;
    logic [7:0]     y_op;
    logic           cin;
    logic [8:0]     sum;
    logic           sin;
    logic [7:0]     res;
    logic           cout;
    logic           arith;
    logic           writes;
    logic [2:0]     rd_var;
    logic [8:0]     inc_lo;
    logic [7:0]     inc_hi;
    logic [7:0]     inc_step;

    assign launch = clk_en && reg_wr && (reg_addr == OFS_MI_HI) && (state_reg == ST_IDLE);
    assign commit = clk_en && (state_reg == ST_EXEC) && (ph_reg == PH4);
    // Conditional variant skips everything when carry is clear
    assign skip   = mi_reg.cnd && !cc_reg[FLG_C];
    assign rd_var = {mi_reg.word, mi_reg.flg, mi_reg.cnd};

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for the far-side signals

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reply_sync_reg <= 2'h0;
            busy_sync_reg  <= 2'h0;
            dal_s1_reg     <= RST_WORD;
            dal_s2_reg     <= RST_WORD;
        end else if (clk_en) begin
            reply_sync_reg <= {reply_sync_reg[0], reply_in};
            busy_sync_reg  <= {busy_sync_reg[0], busy_in};
            dal_s1_reg     <= bus_addr_data_lines_in;
            dal_s2_reg     <= dal_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase counter, free running four phases per microcycle

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ph_reg <= PH1;
        end else if (clk_en) begin
            ph_reg <= ph_reg + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand addressing

    always_comb begin
        is_rs = (mi_reg.op == OP_SHR) && mi_reg.word;
        first = !cyc_reg;
        last  = !mi_reg.word || cyc_reg;
        // Flip only the effective address; mi_reg itself never changes
        a_eff = cyc_reg ? (mi_reg.afld ^ 4'h1) : mi_reg.afld;
        b_eff = cyc_reg ? (mi_reg.bfld ^ 4'h1) : mi_reg.bfld;
        a_byte = rf_reg[a_eff];
        // Odd B on a non right-shift word: high half is the sign fill
        if (cyc_reg && mi_reg.bfld[0] && !is_rs) begin
            b_byte = {8{rf_reg[mi_reg.bfld][7]}};
        end else begin
            b_byte = rf_reg[b_eff];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte ALU; carries between halves ride on lnk_c_reg

    always_comb begin
        x_op  = a_byte;
        y_op  = 8'h00;
        cin   = first ? 1'b0 : lnk_c_reg;
        arith = 1'b1;
        unique case (mi_reg.op)
            OP_ADD:  y_op = b_byte;
            OP_ADDC: begin
                y_op = b_byte;
                cin  = first ? cc_reg[FLG_C] : lnk_c_reg;
            end
            OP_SUB:  begin
                y_op = ~b_byte;
                cin  = first ? 1'b1 : lnk_c_reg;
            end
            OP_TCM:  begin
                x_op = 8'h00;
                y_op = ~b_byte;
                cin  = first ? 1'b1 : lnk_c_reg;
            end
            OP_INC1: cin  = first ? 1'b1 : lnk_c_reg;
            OP_INC2: y_op = first ? 8'h02 : 8'h00;
            OP_DEC1: y_op = 8'hff;
            default: arith = 1'b0;
        endcase
        sum = {1'b0, x_op} + {1'b0, y_op} + {8'h00, cin};
    end

    always_comb begin
        // Shift input: carry flag, the other half's spill, or zero
        sin  = first ? (mi_reg.wcy && cc_reg[FLG_C]) : lnk_c_reg;
        cout = sum[8];
        unique case (mi_reg.op)
            OP_MOV:  res = b_byte;
            OP_AND:  res = a_byte & b_byte;
            OP_OR:   res = a_byte | b_byte;
            OP_XOR:  res = a_byte ^ b_byte;
            OP_OCM:  res = ~b_byte;
            OP_SHL:  begin
                res  = {a_byte[6:0], sin};
                cout = a_byte[7];
            end
            OP_SHR:  begin
                res  = {sin, a_byte[7:1]};
                cout = a_byte[0];
            end
            default: res = sum[7:0];
        endcase
        writes = (mi_reg.op != OP_LAUX) && (mi_reg.op != OP_READ);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read address increments: low byte in A, high byte in B

    always_comb begin
        inc_step = ((rd_var == RD_IB2) || (rd_var == RD_IW2)) ? 8'h02 : 8'h01;
        inc_lo   = {1'b0, rf_reg[mi_reg.afld]} + {1'b0, inc_step};
        inc_hi   = rf_reg[mi_reg.bfld] + {7'h00, lnk_c_reg};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file: datapath writes win over the register port

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 16; i++) begin
                rf_reg[i] <= RST_BYTE;
            end
        end else if (clk_en) begin
            if (reg_wr && (reg_addr <= OFS_RF_LAST)) begin
                rf_reg[reg_addr[3:0]] <= reg_wdata;
            end
            // Result lands at the flipped A address, so odd A swaps
            if (commit && !skip && writes) begin
                rf_reg[a_eff] <= res;
            end
            // Auto-increment reads: low byte at address drop, high byte next
            if ((state_reg == ST_RADDR) && (ph_reg == PH4) && (rd_var != RD_PLAIN)
                && (rd_var != RD_ACK)) begin
                rf_reg[mi_reg.afld] <= inc_lo[7:0];
            end
            if ((state_reg == ST_RPOST) && (ph_reg == PH4)
                && ((rd_var == RD_IW1) || (rd_var == RD_IW2))) begin
                rf_reg[mi_reg.bfld] <= inc_hi;
            end
        end
    end

    // Auxiliary register: loaded only, no arithmetic path reaches it
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            aux_reg <= RST_BYTE;
        end else if (commit && !skip && (mi_reg.op == OP_LAUX)) begin
            aux_reg <= a_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Microword capture

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mi_lo_reg <= RST_BYTE;
            mi_reg    <= mwob_mi_t'(RST_WORD);
        end else if (clk_en && reg_wr) begin
            if (reg_addr == OFS_MI_LO) begin
                mi_lo_reg <= reg_wdata;
            end
            if (launch) begin
                mi_reg <= mwob_mi_t'({reg_wdata, mi_lo_reg});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cyc_reg   <= 1'b0;
            retry_reg <= 1'b0;
        end else if (clk_en) begin
            unique case (state_reg)
                ST_IDLE: begin
                    cyc_reg <= 1'b0;
                    if (launch) begin
                        state_reg <= (mwob_op_t'(reg_wdata[7:4]) == OP_READ) ? ST_RCHK
                                                                             : ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    // Data operations stay inside; bus lines untouched here
                    if (ph_reg == PH4) begin
                        if (!skip && mi_reg.word && !cyc_reg) begin
                            cyc_reg <= 1'b1;
                        end else begin
                            cyc_reg   <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RCHK: begin
                    // Sample reply and busy at PH3; a busy bus costs a microcycle
                    if (ph_reg == PH3) begin
                        if (reply_sync_reg[1] || busy_sync_reg[1]) begin
                            retry_reg <= 1'b1;
                        end else begin
                            retry_reg <= 1'b0;
                            state_reg <= ST_RARM;
                        end
                    end
                end
                ST_RARM:  state_reg <= ST_RADDR;
                ST_RADDR: if (ph_reg == PH4) state_reg <= ST_RPOST;
                ST_RPOST: if (ph_reg == PH4) state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: link flags every byte, condition codes on flag variants

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lnk_c_reg <= 1'b0;
            lnk_z_reg <= 1'b0;
            lnk_n_reg <= 1'b0;
            cc_reg    <= 4'h0;
        end else if (clk_en) begin
            if (commit && !skip && writes) begin
                lnk_c_reg <= cout;
                lnk_z_reg <= (res == 8'h00);
                lnk_n_reg <= res[7];
                if (last && mi_reg.flg) begin
                    cc_reg[FLG_C] <= arith || (mi_reg.op == OP_SHL) || (mi_reg.op == OP_SHR)
                                     ? cout : cc_reg[FLG_C];
                    cc_reg[FLG_Z] <= (res == 8'h00) && (!mi_reg.word || lnk_z_reg);
                    cc_reg[FLG_N] <= is_rs ? lnk_n_reg : res[7];
                    cc_reg[FLG_V] <= arith && (x_op[7] == y_op[7]) && (res[7] != x_op[7]);
                end else if (last && mi_reg.wcy
                             && ((mi_reg.op == OP_SHL) || (mi_reg.op == OP_SHR))) begin
                    cc_reg[FLG_C] <= cout;
                end
            end
            // Low byte increment carry feeds the high byte on word reads
            if ((state_reg == ST_RADDR) && (ph_reg == PH4)) begin
                lnk_c_reg <= inc_lo[8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus pins: address out, sync, acknowledge, data-in strobe

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_addr_data_lines_out  <= RST_WORD;
            bus_addr_data_lines_oe_b <= 1'b1;
            bus_ctl                  <= '0;
        end else if (clk_en) begin
            // Write-side lines belong to families outside this block
            bus_ctl.wbyte <= 1'b0;
            bus_ctl.dout  <= 1'b0;
            unique case (state_reg)
                ST_RARM: begin
                    // Both address bytes out together from PH1
                    bus_addr_data_lines_out  <= {rf_reg[mi_reg.bfld], rf_reg[mi_reg.afld]};
                    bus_addr_data_lines_oe_b <= 1'b0;
                end
                ST_RADDR: begin
                    if (ph_reg == PH1) begin
                        bus_ctl.sync <= 1'b1;
                        bus_ctl.iack <= (rd_var == RD_ACK);
                    end
                    if (ph_reg == PH4) begin
                        bus_addr_data_lines_oe_b <= 1'b1;
                    end
                end
                ST_RPOST: begin
                    // Strobe in the PH4 after the address dropped
                    if (ph_reg == PH3) begin
                        bus_ctl.din <= 1'b1;
                    end
                    if (ph_reg == PH4) begin
                        bus_ctl.din  <= 1'b0;
                        bus_ctl.sync <= 1'b0;
                        bus_ctl.iack <= 1'b0;
                    end
                end
                default: begin
                    bus_ctl.din  <= 1'b0;
                    bus_ctl.sync <= 1'b0;
                    bus_ctl.iack <= 1'b0;
                end
            endcase
        end
    end

    // Snapshot of the lines driven during the strobe, for inspection only;
    // the lines pass two synchroniser stages, so the strobe is delayed to match
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            din_pipe_reg <= 2'h0;
            buscap_reg   <= RST_WORD;
        end else if (clk_en) begin
            din_pipe_reg <= {din_pipe_reg[0], bus_ctl.din};
            if (din_pipe_reg[1]) begin
                buscap_reg <= dal_s2_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port read data, one cycle after the strobe

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= RST_BYTE;
            exec_busy <= 1'b0;
        end else if (clk_en) begin
            exec_busy <= (state_reg != ST_IDLE) || launch;
            if (reg_rd) begin
                if (reg_addr <= OFS_RF_LAST) begin
                    reg_rdata <= rf_reg[reg_addr[3:0]];
                end else begin
                    unique case (reg_addr)
                        OFS_FLAGS:    reg_rdata <= {4'h0, cc_reg};
                        OFS_STATUS:   reg_rdata <= {5'h00, retry_reg,
                                                    (state_reg >= ST_RCHK),
                                                    (state_reg != ST_IDLE)};
                        OFS_BUSCAP_L: reg_rdata <= buscap_reg[7:0];
                        OFS_BUSCAP_H: reg_rdata <= buscap_reg[15:8];
                        OFS_AUX:      reg_rdata <= aux_reg;
                        default:      reg_rdata <= 8'h00;
                    endcase
                end
            end
        end
    end

endmodule

// >>> verilog/mwob_unused_guard.sv
// Holds no logic; every design process lives in the core file

// >>> bench/mwob_core_monitor.sv
// Port-level timing checker for the bus read sequencer
`timescale 1ns/10ps
module mwob_core_monitor (
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire logic [15:0]            bus_addr_data_lines_out,
    input  wire logic                   bus_addr_data_lines_oe_b,
    input  wire mwob_pkg::mwob_busctl_t bus_ctl,
    input  wire logic                   exec_busy
);
    import mwob_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // Address stands one microcycle; data-in comes in PH4 of the next one
    sequence s_addr_window;
        !bus_addr_data_lines_oe_b [*4] ##1 bus_addr_data_lines_oe_b;
    endsequence
    sequence s_din_pulse;
        ##7 bus_ctl.din ##1 !bus_ctl.din;
    endsequence
    a_addr_one_mcycle: assert property (
        $fell(bus_addr_data_lines_oe_b) |-> s_addr_window) else $error("address window wrong");
    a_addr_held: assert property (
        !$past(bus_addr_data_lines_oe_b) && !bus_addr_data_lines_oe_b
        |-> $stable(bus_addr_data_lines_out)) else $error("address moved while driven");
    a_sync_in_ph2: assert property (
        $fell(bus_addr_data_lines_oe_b) |=> $rose(bus_ctl.sync)) else $error("sync not in PH2");
    a_din_after_addr: assert property (
        $fell(bus_addr_data_lines_oe_b) |-> s_din_pulse) else $error("data-in out of place");
    a_sync_held_din: assert property (
        $rose(bus_ctl.din) |-> bus_ctl.sync && $past(bus_ctl.sync, 6)) else $error("sync gap");
    a_iack_with_sync: assert property (
        $rose(bus_ctl.iack) |-> $rose(bus_ctl.sync)) else $error("iack apart from sync");
    a_write_lines_idle: assert property (
        !(bus_ctl.wbyte || bus_ctl.dout)) else $error("write lines active");
    a_ctl_needs_exec: assert property (
        (bus_ctl.sync || bus_ctl.din) |-> exec_busy) else $error("bus control while idle");
endmodule
bind mwob_core mwob_core_monitor u_mon (
    .core_clk                 (core_clk),
    .rst_b                    (rst_b),
    .bus_addr_data_lines_out  (bus_addr_data_lines_out),
    .bus_addr_data_lines_oe_b (bus_addr_data_lines_oe_b),
    .bus_ctl                  (bus_ctl),
    .exec_busy                (exec_busy)
);

// >>> bench/mwob_bus_dev.sv
// Behavioural bus device answering data-in with data and reply
`timescale 1ns/10ps
module mwob_bus_dev #(
    parameter logic [15:0] DEV_DATA = 16'h5aa5
) (
    input  wire logic                   core_clk,
    input  wire logic [15:0]            addr_out,
    input  wire logic                   addr_oe_b,
    input  wire mwob_pkg::mwob_busctl_t ctl,
    output logic [15:0]                 lines,
    output logic                        reply
);
    import mwob_pkg::*;
    logic [15:0] last_reg  = 16'h0000;
    logic [1:0]  reply_cnt = 2'h0;
    ////////////////////////////////////////////////////////////////////////
    // Released lines toggle so a stale value never looks valid
    always_comb begin
        if (!addr_oe_b) begin
            lines = addr_out;
        end else if (ctl.din || (reply_cnt != 2'h0)) begin
            lines = DEV_DATA;
        end else begin
            lines = ~last_reg;
        end
    end
    always_ff @(posedge core_clk) begin
        last_reg <= lines;
    end
    // Reply stands from PH1 through PH3 after data-in, so PH3 sees it
    always_ff @(posedge core_clk) begin
        if (ctl.din) begin
            reply_cnt <= 2'h3;
        end else if (reply_cnt != 2'h0) begin
            reply_cnt <= reply_cnt - 2'h1;
        end
    end
    assign reply = (reply_cnt != 2'h0);
endmodule

// >>> bench/micro_word_operand_bus_read_tb_top.sv
// Self-checking testbench for the word-operand datapath and bus read
`timescale 1ns/10ps
module micro_word_operand_bus_read_tb_top;
    import mwob_pkg::*;
    logic         core_clk  = 1'b0;
    logic         rst_b     = 1'b0;
    logic         clk_en    = 1'b1;
    logic [7:0]   reg_addr  = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr    = 1'b0;
    logic         reg_rd    = 1'b0;
    logic         busy_in   = 1'b0;
    logic [7:0]   reg_rdata;
    logic [15:0]  lines_in;
    logic [15:0]  lines_out;
    logic         lines_oe_b;
    mwob_busctl_t bus_ctl;
    logic         reply;
    logic         exec_busy;
    logic [15:0]  seen_addr;
    logic         seen_iack;
    int           fail_count = 0;
    int           n_checks   = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock enable driven by the bench; one scenario freezes the block
    mwob_core DUT (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bus_addr_data_lines_in(lines_in), .bus_addr_data_lines_out(lines_out),
        .bus_addr_data_lines_oe_b(lines_oe_b), .bus_ctl(bus_ctl), .reply_in(reply),
        .busy_in(busy_in), .exec_busy(exec_busy));
    mwob_bus_dev u_dev (.core_clk(core_clk), .addr_out(lines_out), .addr_oe_b(lines_oe_b),
        .ctl(bus_ctl), .lines(lines_in), .reply(reply));
    always #10 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, v});
    endtask
    // Bounded wait for the microword to finish, noting bus activity
    task automatic finish();
        seen_iack = 1'b0;
        seen_addr = 16'h0000;
        for (int i = 0; i < 200; i++) begin
            @(posedge core_clk);
            #1;
            if (lines_oe_b === 1'b0) seen_addr = lines_out;
            if (bus_ctl.iack === 1'b1) seen_iack = 1'b1;
            if (i > 0 && exec_busy === 1'b0) break;
        end
        check("exec_busy", 16'h0000, {15'h0, exec_busy});
    endtask
    task automatic run(input logic [15:0] w);
        wr(OFS_MI_LO, w[7:0]);
        wr(OFS_MI_HI, w[15:8]);
        finish();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_load();
        logic [7:0] init [16] = '{8'hff, 8'h01, 8'h01, 8'h02, 8'h00, 8'h80, 8'h01, 8'h00,
                                  8'h34, 8'h12, 8'h01, 8'h00, 8'h02, 8'h81, 8'h80, 8'h80};
        rd_chk(OFS_FLAGS, 8'h00);
        rd_chk(OFS_STATUS, 8'h00);
        for (int i = 0; i < 16; i++) wr(i[7:0], init[i]);
    endtask
    task automatic t_word_forms();
        run(16'h1820);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h01, 8'h04);
        wr(OFS_MI_HI, 8'h18);
        finish();
        rd_chk(8'h01, 8'h06);
        run(16'h0856);
        rd_chk(8'h07, 8'hff);
        rd_chk(8'h06, 8'h80);
        run(16'h188b);
        rd_chk(8'h0b, 8'h34);
        rd_chk(8'h0a, 8'h13);
    endtask
    task automatic t_shifts();
        run(16'h99ee);
        rd_chk(8'h0f, 8'h01);
        rd_chk(OFS_FLAGS, 8'h01);
        run(16'ha9dd);
        rd_chk(8'h0d, 8'hc0);
        rd_chk(8'h0c, 8'h81);
        rd_chk(OFS_FLAGS, 8'h00);
    endtask
    task automatic t_variants();
        run(16'h0201);
        rd_chk(8'h01, 8'h06);
        run(16'h0442);
        check("addr", 16'h0000, seen_addr);
        rd_chk(OFS_FLAGS, 8'h04);
        run(16'hc003);
        rd_chk(8'h03, 8'h04);
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(8'h03, 8'h55);
        clk_en <= 1'b1;
        rd_chk(8'h03, 8'h04); // Frozen write ignored
    endtask
    // Read with increment, then acknowledge read of the bumped address
    task automatic t_reads();
        run(16'he298);
        check("addr", 16'h1234, seen_addr);
        check("iack", 16'h0000, {15'h0, seen_iack});
        rd_chk(8'h08, 8'h35);
        rd_chk(OFS_BUSCAP_L, 8'ha5);
        rd_chk(OFS_BUSCAP_H, 8'h5a);
        run(16'hea98);
        check("addr", 16'h1235, seen_addr);
        check("iack", 16'h0001, {15'h0, seen_iack});
        rd_chk(8'h08, 8'h35);
        rd_chk(OFS_FLAGS, 8'h04);
    endtask
    task automatic t_busy_retry();
        logic [7:0] v;
        @(posedge core_clk);
        busy_in <= 1'b1;
        wr(OFS_MI_LO, 8'h98);
        wr(OFS_MI_HI, 8'he0);
        repeat (20) @(posedge core_clk);
        #1 check("oe_b", 16'h0001, {15'h0, lines_oe_b});
        rd(OFS_STATUS, v);
        check("retry", 16'h0001, {15'h0, v[STS_RETRY]});
        @(posedge core_clk);
        busy_in <= 1'b0;
        finish();
        check("addr", 16'h1235, seen_addr);
        wr(8'h08, 8'hff);
        run(16'he898);
        check("addr", 16'h12ff, seen_addr);
        rd_chk(8'h08, 8'h01);
        rd_chk(8'h09, 8'h13);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset_and_load();
        t_word_forms();
        t_shifts();
        t_variants();
        t_reads();
        t_busy_retry();
        complete_run();
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #400000;
        fail_count++;
        complete_run();
    end
endmodule
